// ==== verilog/serial_channel_host_sequencer.v ====
// Command interpreter and per-channel exchange registers of the serial link
//
// How it works
// - Normal-mode transfer end posts four fault/state bytes
// - Incoming bytes 0-11 fill words 0-2
// - Field outputs/inputs/analog ride the words unchanged
// - Start 0x9NN, command clears at end
// - Data register flags channels failing start
// - Data register flags failed transfer channels
// - Transfer finishes within 100 microseconds
// - Setup start opens pass-through access mode
// - Channels idle after reset or halt
// - Access code selects size and direction
// - Access errors set data register bits
// - Start exposes table pointer in word 2
// - Header: type, write, autoinc, addrsize, size
`timescale 1ns/1ps
`include "serial_channel_defines.vh"
module serial_channel_host_sequencer #(
    parameter CH = 8
) (
    input  wire           core_clk,
    input  wire           srst,
    input  wire [7:0]     reg_addr,
    input  wire [31:0]    reg_wdata,
    input  wire           reg_wr,
    input  wire           reg_rd,
    output reg  [31:0]    reg_rdata,
    output reg            link_req,
    output reg  [1:0]     link_op,
    output reg  [2:0]     link_chan,
    output reg  [7:0]     link_header,
    output reg  [15:0]    link_addr,
    output reg  [95:0]    link_out,
    input  wire           link_ack,
    input  wire           link_fail,
    input  wire [95:0]    link_in,
    input  wire [31:0]    link_status,
    input  wire [15:0]    link_table_ptr
);
    // ----------------------------------------------------------------
    // State and storage
    // ----------------------------------------------------------------
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_SCAN = 3'h1;
    localparam [2:0] S_WAIT = 3'h2;
    localparam [2:0] S_DONE = 3'h3;
    localparam [2:0] S_HALT = 3'h4;
    localparam [3:0] LAST   = CH[3:0];
    // Deadline count is loaded one short: the expiry tick itself is the last microsecond
    localparam integer XFER_LAST = `XFER_LIMIT_US - 1;

    reg  [31:0]   command;
    reg  [31:0]   data_status;
    reg  [CH-1:0] running;
    reg  [CH-1:0] setup_mode;
    reg  [CH-1:0] sel_mask;
    reg  [CH-1:0] fail_bits;
    reg  [2:0]    state;
    reg  [3:0]    idx;
    reg  [7:0]    op_kind;
    reg  [6:0]    us_left;
    reg  [31:0]   cs_reg   [0:CH-1];
    reg  [31:0]   out_word0 [0:CH-1];
    reg  [31:0]   out_word1 [0:CH-1];
    reg  [31:0]   out_word2 [0:CH-1];
    reg  [31:0]   in_word0 [0:CH-1];
    reg  [31:0]   in_word1 [0:CH-1];
    reg  [31:0]   in_word2 [0:CH-1];
    reg  [31:0]   rd_mux;

    wire          tick;
    wire          hdr_valid;
    wire [CH-1:0] lower_mask;
    wire [2:0]    cur       = idx[2:0];
    wire [7:0]    wr_code   = reg_wdata[`CMD_CODE_HI:`CMD_CODE_LO];
    wire          cmd_write = reg_wr && (reg_addr == `REG_COMMAND);
    wire          wr_ignore = reg_wdata[`CMD_IGNORE_BIT];
    wire          wr_halt   = (wr_code == `CMD_HALT_ALL);
    wire          is_go     = (op_kind == `CMD_TRANSFER_GO);
    wire          is_start  = (op_kind == `CMD_NORMAL_START)
                           || (op_kind == `CMD_SETUP_START);
    wire          wr_known  = (wr_code == `CMD_NORMAL_START)
                           || (wr_code == `CMD_SETUP_START)
                           || (wr_code == `CMD_TRANSFER_GO);
    wire          expired   = is_go && (us_left == 7'h00) && tick;
    wire          chan_hit  = reg_addr[`CHAN_REGION_BIT]
                           && ({1'b0, reg_addr[`CHAN_SEL_HI:`CHAN_SEL_LO]} < LAST);
    wire [2:0]    acc_chan  = reg_addr[`CHAN_SEL_HI:`CHAN_SEL_LO];
    wire [1:0]    acc_word  = reg_addr[`CHAN_WORD_HI:`CHAN_WORD_LO];

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    us_tick #(
        .DIV (`US_CYCLES)
    ) u_tick (
        .core_clk (core_clk),
        .srst     (srst),
        .tick     (tick)
    );

    access_header u_hdr (
        .code       (cs_reg[cur][31:24]),
        .valid      (hdr_valid),
        .write_flag (),
        .size       ()
    );

    // ----------------------------------------------------------------
    // Command sequencer
    // ----------------------------------------------------------------
    always @(posedge core_clk) begin
        link_req <= 1'b0;
        if (srst) begin
            command     <= `RESET_ZERO;
            data_status <= `RESET_ZERO;
            running     <= {CH{1'b0}};
            setup_mode  <= {CH{1'b0}};
            sel_mask    <= {CH{1'b0}};
            fail_bits   <= {CH{1'b0}};
            state       <= S_IDLE;
            idx         <= 4'h0;
            op_kind     <= 8'h00;
            us_left     <= 7'h00;
            link_op     <= 2'h0;
            link_chan   <= 3'h0;
            link_header <= 8'h00;
            link_addr   <= 16'h0000;
            link_out    <= 96'h0;
        end else if (cmd_write && !wr_ignore && wr_halt) begin
            // Halt is taken in any state and aborts what is under way
            command <= reg_wdata;
            state   <= S_HALT;
        end else begin
            if (tick && (us_left != 7'h00)) begin
                us_left <= us_left - 7'h01;
            end
            case (state)
                S_IDLE: begin
                    // A busy command register refuses other writes
                    if (cmd_write && !wr_ignore) begin
                        command   <= reg_wdata;
                        sel_mask  <= reg_wdata[CH-1:0];
                        op_kind   <= wr_code;
                        fail_bits <= wr_known ? {CH{1'b0}} : reg_wdata[CH-1:0];
                        idx       <= 4'h0;
                        us_left   <= XFER_LAST[6:0];
                        state     <= wr_known ? S_SCAN : S_DONE;
                    end
                end
                S_SCAN: begin
                    if (expired) begin
                        fail_bits <= fail_bits | (sel_mask & ~lower_mask);
                        state     <= S_DONE;
                    end else if (idx == LAST) begin
                        state <= S_DONE;
                    end else if (!sel_mask[cur]) begin
                        idx <= idx + 4'h1;
                    end else if (is_go && !running[cur]) begin
                        fail_bits[cur] <= 1'b1;
                        idx            <= idx + 4'h1;
                    end else if (is_go && setup_mode[cur] && !hdr_valid) begin
                        fail_bits[cur] <= 1'b1;
                        idx            <= idx + 4'h1;
                    end else begin
                        link_req    <= 1'b1;
                        link_chan   <= cur;
                        link_addr   <= cs_reg[cur][15:0];
                        link_out    <= {out_word2[cur], out_word1[cur],
                                        out_word0[cur]};
                        link_header <= 8'h00;
                        if (op_kind == `CMD_NORMAL_START) begin
                            link_op <= `OP_NORMAL_START;
                        end else if (op_kind == `CMD_SETUP_START) begin
                            link_op <= `OP_SETUP_START;
                        end else if (setup_mode[cur]) begin
                            link_op     <= `OP_ACCESS;
                            link_header <= cs_reg[cur][31:24];
                        end else begin
                            link_op <= `OP_CYCLE;
                        end
                        state <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    if (expired) begin
                        fail_bits <= fail_bits | (sel_mask & ~lower_mask);
                        state     <= S_DONE;
                    end else if (link_ack) begin
                        if (link_fail) begin
                            fail_bits[cur] <= 1'b1;
                        end
                        idx   <= idx + 4'h1;
                        state <= S_SCAN;
                    end
                end
                S_DONE: begin
                    command     <= `RESET_ZERO;
                    data_status <= {{(32-CH){1'b0}}, fail_bits};
                    if (is_start) begin
                        running <= (running & ~sel_mask) | (sel_mask & ~fail_bits);
                        if (op_kind == `CMD_SETUP_START) begin
                            setup_mode <= setup_mode | (sel_mask & ~fail_bits);
                        end else begin
                            setup_mode <= setup_mode & ~sel_mask;
                        end
                    end
                    state <= S_IDLE;
                end
                S_HALT: begin
                    running     <= {CH{1'b0}};
                    setup_mode  <= {CH{1'b0}};
                    command     <= `RESET_ZERO;
                    data_status <= `RESET_ZERO;
                    state       <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Per-channel exchange registers
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < CH; g = g + 1) begin : chan
            localparam [3:0] MY = g;
            wire host_wr = reg_wr && chan_hit && (acc_chan == MY[2:0]);
            // An answer that arrives after its deadline is dropped, so a
            // slow link cannot overwrite words the host already reads.
            wire answer  = (state == S_WAIT) && link_ack && !expired && (idx == MY);

            assign lower_mask[g] = (MY < idx);

            always @(posedge core_clk) begin
                if (srst) begin
                    cs_reg[g]    <= `RESET_ZERO;
                    out_word0[g] <= `RESET_ZERO;
                    out_word1[g] <= `RESET_ZERO;
                    out_word2[g] <= `RESET_ZERO;
                    in_word0[g]  <= `RESET_ZERO;
                    in_word1[g]  <= `RESET_ZERO;
                    in_word2[g]  <= `RESET_ZERO;
                end else begin
                    if (host_wr) begin
                        case (acc_word)
                            `WORD_CS:    cs_reg[g]    <= reg_wdata;
                            `WORD_XFER0: out_word0[g] <= reg_wdata;
                            `WORD_XFER1: out_word1[g] <= reg_wdata;
                            default:     out_word2[g] <= reg_wdata;
                        endcase
                    end
                    // The link answer wins over a host write in the same cycle
                    if (answer) begin
                        if (is_start) begin
                            cs_reg[g]   <= link_status;
                            in_word2[g] <= {16'h0000, link_table_ptr};
                        end else if (setup_mode[g]) begin
                            in_word0[g] <= link_in[31:0];
                            in_word1[g] <= link_in[63:32];
                            in_word2[g] <= link_in[95:64];
                        end else begin
                            cs_reg[g]   <= link_status;
                            in_word0[g] <= link_in[31:0];
                            in_word1[g] <= link_in[63:32];
                            in_word2[g] <= link_in[95:64];
                        end
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Register read port
    // ----------------------------------------------------------------
    always @* begin
        rd_mux = `RESET_ZERO;
        if (reg_addr == `REG_COMMAND) begin
            rd_mux = command;
        end else if (reg_addr == `REG_DATA) begin
            rd_mux = data_status;
        end else if (chan_hit) begin
            case (acc_word)
                `WORD_CS:    rd_mux = cs_reg[acc_chan];
                `WORD_XFER0: rd_mux = in_word0[acc_chan];
                `WORD_XFER1: rd_mux = in_word1[acc_chan];
                default:     rd_mux = in_word2[acc_chan];
            endcase
        end
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge core_clk) begin
        if (srst) begin
            reg_rdata <= `RESET_ZERO;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end else begin
            reg_rdata <= `RESET_ZERO;
        end
    end
endmodule // serial_channel_host_sequencer

// ==== verilog/serial_channel_defines.vh ====
// Constants shared by the serial channel command sequencer and its helpers
`ifndef SERIAL_CHANNEL_DEFINES_VH
`define SERIAL_CHANNEL_DEFINES_VH

// ----------------------------------------------------------------
// Register map (byte addresses on the plain register port)
// ----------------------------------------------------------------
`define REG_COMMAND        8'h00
`define REG_DATA           8'h04
`define CHAN_REGION_BIT    7
`define CHAN_SEL_HI        6
`define CHAN_SEL_LO        4
`define CHAN_WORD_HI       3
`define CHAN_WORD_LO       2
`define WORD_CS            2'h0
`define WORD_XFER0         2'h1
`define WORD_XFER1         2'h2
`define WORD_XFER2         2'h3

// ----------------------------------------------------------------
// Command word layout and codes
// ----------------------------------------------------------------
`define CMD_CODE_HI        15
`define CMD_CODE_LO        8
`define CMD_IGNORE_BIT     14
`define CMD_HALT_ALL       8'h08
`define CMD_NORMAL_START   8'h09
`define CMD_SETUP_START    8'h0f
`define CMD_TRANSFER_GO    8'h10

// ----------------------------------------------------------------
// Link operation codes toward the low-level link engine
// ----------------------------------------------------------------
`define OP_NORMAL_START    2'h0
`define OP_SETUP_START     2'h1
`define OP_CYCLE           2'h2
`define OP_ACCESS          2'h3

// ----------------------------------------------------------------
// Low-level data command header fields
// ----------------------------------------------------------------
`define HDR_TYPE_HI        7
`define HDR_TYPE_LO        6
`define HDR_TYPE_DATA      2'h1
`define HDR_WRITE_BIT      5
`define HDR_RID_BIT        4
`define HDR_AUTOINC_BIT    3
`define HDR_ADDRSIZE_BIT   2
`define HDR_SIZE_HI        1
`define HDR_SIZE_LO        0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_MHZ            200
`define US_CYCLES          (`CLK_MHZ * 1)
`define XFER_LIMIT_US      100
`define RESET_ZERO         32'h0000_0000

`endif

// ==== verilog/us_tick.v ====
// Divider that gives a one-cycle enable pulse once per microsecond
`timescale 1ns/1ps
module us_tick #(
    parameter DIV = 200
) (
    input  wire        core_clk,
    input  wire        srst,
    output reg         tick
);
    reg [15:0] count;

    always @(posedge core_clk) begin
        if (srst) begin
            count <= 16'h0000;
            tick  <= 1'b0;
        end else if (count == DIV[15:0] - 16'h0001) begin
            count <= 16'h0000;
            tick  <= 1'b1;
        end else begin
            count <= count + 16'h0001;
            tick  <= 1'b0;
        end
    end
endmodule // us_tick

// ==== verilog/access_header.v ====
// Checks a remote access code and splits it into low-level header fields
`timescale 1ns/1ps
`include "serial_channel_defines.vh"
module access_header (
    input  wire [7:0]  code,
    output wire        valid,
    output wire        write_flag,
    output wire [1:0]  size
);
    // The access code is already a data command header with a two-byte
    // address, no auto increment and no stored-data flag.
    assign valid = (code[`HDR_TYPE_HI:`HDR_TYPE_LO] == `HDR_TYPE_DATA)
                 && !code[`HDR_RID_BIT]
                 && !code[`HDR_AUTOINC_BIT]
                 && code[`HDR_ADDRSIZE_BIT];
    assign write_flag = code[`HDR_WRITE_BIT];
    assign size       = code[`HDR_SIZE_HI:`HDR_SIZE_LO];
endmodule // access_header

// ==== sim/sequencer_monitor.sv ====
// Port-level assertions for the serial channel sequencer
`timescale 1ns/1ps
module sequencer_monitor #(
    parameter CH = 8
) (
    input wire        core_clk,
    input wire        srst,
    input wire [7:0]  reg_addr,
    input wire [31:0] reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [31:0] reg_rdata,
    input wire        link_req,
    input wire [1:0]  link_op,
    input wire [2:0]  link_chan,
    input wire [7:0]  link_header,
    input wire [15:0] link_addr,
    input wire [95:0] link_out,
    input wire        link_ack,
    input wire        link_fail,
    input wire [95:0] link_in,
    input wire [31:0] link_status,
    input wire [15:0] link_table_ptr
);
    wire halt_wr = reg_wr && reg_addr == 8'h00 && reg_wdata[15:8] == 8'h08 && !reg_wdata[14];
    reg  pend;

    // A halt abandons the request in flight, so it also ends the wait
    always @(posedge core_clk) begin
        if (srst) begin
            pend <= 1'b0;
        end else if (link_req) begin
            pend <= 1'b1;
        end else if (link_ack || halt_wr) begin
            pend <= 1'b0;
        end
    end

    default clocking mon_cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside the read answer cycle");
    req_pulse_a: assert property (link_req |=> !link_req)
        else $error("link request longer than one cycle");
    one_req_a: assert property (link_req |-> !pend)
        else $error("second link request before the answer");
    chan_range_a: assert property (link_req |-> link_chan < CH)
        else $error("link request on a channel that does not exist");
    plain_header_a: assert property (link_req && link_op != 2'h3 |-> link_header == 8'h00)
        else $error("header not zero on a non-access request");
    access_code_a: assert property (link_req && link_op == 2'h3 |->
        link_header[7:6] == 2'h1 && link_header[4:2] == 3'h1)
        else $error("access header outside the legal codes");
    link_stand_a: assert property (!link_req |->
        $stable({link_op, link_chan, link_header, link_addr, link_out}))
        else $error("link request fields moved between requests");
    halt_quiet_a: assert property (halt_wr |-> ##2 !link_req [*3])
        else $error("link request after a halt");

    cover property (link_req && link_op == 2'h0);
    cover property (link_req && link_op == 2'h1);
    cover property (link_req && link_op == 2'h2);
    cover property (link_req && link_op == 2'h3);
endmodule // sequencer_monitor

bind serial_channel_host_sequencer sequencer_monitor #(.CH(CH)) u_sequencer_monitor (
    .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_req(link_req),
    .link_op(link_op), .link_chan(link_chan), .link_header(link_header),
    .link_addr(link_addr), .link_out(link_out), .link_ack(link_ack),
    .link_fail(link_fail), .link_in(link_in), .link_status(link_status),
    .link_table_ptr(link_table_ptr)
);

// ==== sim/link_engine_model.sv ====
// Behavioural link engine answering the sequencer's channel requests
`timescale 1ns/1ps
module link_engine_model (
    input  wire        core_clk,
    input  wire        srst,
    input  wire        link_req,
    input  wire [2:0]  link_chan,
    input  wire [7:0]  fail_chans,
    input  wire [15:0] delay,
    output reg         link_ack = 1'b0,
    output reg         link_fail = 1'b0,
    output reg  [95:0] link_in = 96'h0,
    output reg  [31:0] link_status = 32'h0,
    output reg  [15:0] link_table_ptr = 16'h0
);
    reg     busy = 1'b0;
    reg     [15:0] cnt = 16'h0;
    reg     [2:0]  chan = 3'h0;
    integer k;
    wire    fire = !srst && !link_req && busy && cnt == 16'h0;

    // Answer fields only mean something with the ack, so they toggle otherwise
    always @(posedge core_clk) begin
        link_ack <= fire;
        if (srst) begin
            busy <= 1'b0;
            link_fail <= 1'b0;
            link_in <= 96'h0;
            link_status <= 32'h0;
            link_table_ptr <= 16'h0;
        end else if (fire) begin
            busy <= 1'b0;
            link_fail <= fail_chans[chan];
            link_status <= {24'hc0035a, 5'h0, chan};
            link_table_ptr <= {13'h0020, chan};
            for (k = 0; k < 12; k = k + 1) begin
                link_in[8*k +: 8] <= {1'b1, chan, 4'(k)};
            end
        end else begin
            link_fail <= ~link_fail;
            link_in <= ~link_in;
            link_status <= ~link_status;
            link_table_ptr <= ~link_table_ptr;
            if (link_req) begin
                busy <= 1'b1;
                cnt <= delay;
                chan <= link_chan;
            end else if (busy) begin
                cnt <= cnt - 16'h1;
            end
        end
    end
endmodule // link_engine_model

// ==== sim/serial_channel_host_sequencer_test.sv ====
// Self-checking bench for the serial channel sequencer
`timescale 1ns/1ps
module serial_channel_host_sequencer_test;
    reg          core_clk = 1'b0;
    reg          srst = 1'b1;
    reg  [7:0]   reg_addr = 8'h00;
    reg  [31:0]  reg_wdata = 32'h0;
    reg          reg_wr = 1'b0;
    reg          reg_rd = 1'b0;
    reg  [7:0]   fail_chans = 8'h00;
    reg  [15:0]  delay = 16'h0004;
    wire [31:0]  reg_rdata;
    wire [31:0]  link_status;
    wire [95:0]  link_out;
    wire [95:0]  link_in;
    wire [15:0]  link_addr;
    wire [15:0]  link_table_ptr;
    wire [7:0]   link_header;
    wire [2:0]   link_chan;
    wire [1:0]   link_op;
    wire         link_req;
    wire         link_ack;
    wire         link_fail;
    integer      failures = 0;
    integer      checks_done = 0;
    integer      waited;
    integer      i;
    reg  [31:0]  rv;
    reg  [7:0]   code;

    always #2.5 core_clk = ~core_clk;

    serial_channel_host_sequencer #(.CH(8)) DUT (
        .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_req(link_req),
        .link_op(link_op), .link_chan(link_chan), .link_header(link_header),
        .link_addr(link_addr), .link_out(link_out), .link_ack(link_ack),
        .link_fail(link_fail), .link_in(link_in), .link_status(link_status),
        .link_table_ptr(link_table_ptr));

    link_engine_model far_end (
        .core_clk(core_clk), .srst(srst), .link_req(link_req), .link_chan(link_chan),
        .fail_chans(fail_chans), .delay(delay), .link_ack(link_ack),
        .link_fail(link_fail), .link_in(link_in), .link_status(link_status),
        .link_table_ptr(link_table_ptr));

    task test_done;
        begin
            $display("checks %0d failures %0d", checks_done, failures);
            if (failures == 0 && checks_done > 0) begin
                $display("Simulation passed");
            end else begin
                $display("Simulation failed");
            end
            $finish;
        end
    endtask

    task cmp(input [8*12:1] name, input [31:0] exp, input [31:0] got);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("CHECK FAILED %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask

    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge core_clk);
            reg_wr <= 1'b1;
            reg_addr <= a;
            reg_wdata <= d;
            @(posedge core_clk);
            reg_wr <= 1'b0;
        end
    endtask

    // Read data is only valid in the cycle after the strobe
    task rd(input [7:0] a);
        begin
            @(posedge core_clk);
            reg_rd <= 1'b1;
            reg_addr <= a;
            @(posedge core_clk);
            reg_rd <= 1'b0;
            #1;
            rv = reg_rdata;
        end
    endtask

    task rchk(input [7:0] a, input [31:0] exp, input [8*12:1] name);
        begin
            rd(a);
            cmp(name, exp, rv);
        end
    endtask

    task cmd(input [31:0] c, input integer lim);
        begin
            wr(8'h00, c);
            waited = 0;
            rv = 32'h1;
            while (rv !== 32'h0 && waited < lim) begin
                rd(8'h00);
                waited = waited + 2;
            end
            if (rv !== 32'h0) begin
                failures = failures + 1;
                $display("CHECK FAILED command expected 00000000 seen %h", rv);
                test_done;
            end
        end
    endtask

    function [31:0] inw(input [2:0] c, input integer w);
        integer k;
        begin
            for (k = 0; k < 4; k = k + 1) begin
                inw[8*k +: 8] = {1'b1, c, 4'(4 * w + k)};
            end
        end
    endfunction

    task s_idle;
        begin
            rchk(8'h00, 32'h0, "command");
            rchk(8'h40, 32'h0, "unmapped");
            cmd(32'h0000_0800, 40);
            rchk(8'h04, 32'h0, "data");
            cmd(32'h0000_1001, 40);
            rchk(8'h04, 32'h1, "data");
            cmd(32'h0000_2005, 40);
            rchk(8'h04, 32'h5, "data");
        end
    endtask

    task s_start;
        begin
            delay <= 16'd2000;
            fail_chans <= 8'h02;
            wr(8'h00, 32'h0000_0903);
            wr(8'h00, 32'h0000_1001);
            rchk(8'h00, 32'h0000_0903, "command");
            cmd(32'h0000_0800, 40);
            cmd(32'h0000_0903, 9000);
            rchk(8'h04, 32'h2, "data");
            wr(8'h00, 32'h0000_5001);
            rchk(8'h00, 32'h0, "command");
            rchk(8'h04, 32'h2, "data");
            rd(8'h8c);
            cmp("table_ptr", 32'h0100, {16'h0, rv[15:0]});
            rchk(8'h80, 32'hc003_5a00, "cs");
        end
    endtask

    task s_go;
        begin
            delay <= 16'd5;
            fail_chans <= 8'h00;
            wr(8'h84, 32'h0000_a5c3);
            wr(8'h88, 32'h1234_5678);
            wr(8'h8c, 32'h9abc_def0);
            cmd(32'h0000_1001, 400);
            rchk(8'h04, 32'h0, "data");
            rchk(8'h80, 32'hc003_5a00, "cs");
            for (i = 0; i < 3; i = i + 1) begin
                rchk(8'h84 + 8'(4 * i), inw(3'h0, i), "in_word");
            end
            cmp("out0", 32'h0000_a5c3, link_out[31:0]);
            cmp("out1", 32'h1234_5678, link_out[63:32]);
            cmp("out2", 32'h9abc_def0, link_out[95:64]);
            cmp("op", 32'h2, {30'h0, link_op});
            cmp("chan", 32'h0, {29'h0, link_chan});
            delay <= 16'd30000;
            cmd(32'h0000_1001, 22000);
            cmp("deadline", 32'h1, {31'h0, waited <= 20220});
            rchk(8'h04, 32'h1, "data");
        end
    endtask

    task s_setup;
        begin
            delay <= 16'd3;
            cmd(32'h0000_0800, 40);
            cmd(32'h0000_0f01, 400);
            rchk(8'h04, 32'h0, "data");
            for (i = 0; i < 8; i = i + 1) begin
                code = {2'h1, i[2], 3'h1, i[1:0]};
                wr(8'h84, i * 32'h111);
                wr(8'h80, {code, 8'h00, 16'h0200 + 16'(2 * i)});
                cmd(32'h0000_1001, 400);
                rchk(8'h04, 32'h0, "data");
                cmp("header", {24'h0, code}, {24'h0, link_header});
                cmp("addr", 32'h0200 + 2 * i, {16'h0, link_addr});
                cmp("wr_data", i * 32'h111, link_out[31:0]);
                rchk(8'h84, inw(3'h0, 0), "read_data");
            end
            wr(8'h80, 32'h5000_0200);
            cmd(32'h0000_1001, 400);
            rchk(8'h04, 32'h1, "data");
        end
    endtask

    initial begin
        repeat (10) @(posedge core_clk);
        srst <= 1'b0;
        s_idle;
        s_start;
        s_go;
        s_setup;
        test_done;
    end
endmodule // serial_channel_host_sequencer_test
